// [core/intc_pkg.sv]
// Function
// - vector-map select is status-one bit 3, resets to 1, writable, set/clear
// - low-RAM map select is status-one bit 11, resets to 1, writable; 0 is test
// - boot-source bit is bit 8 of external config two, loaded from pin at reset
// - expansion enable is bit 0 of expansion control, resets 0, writable
// - fetch region chosen from map, RAM map, expansion enable and boot source
// - low RAM blocks act as plain RAM unless a low-RAM vector map is selected
// - reset vector always from boot ROM or zone 7 per pin, never expansion
// - boot-source pin level latched into the bit at reset, software may change it
// - reset disables the expansion table; once enabled with vector-map select 1, all vectors but reset come from it
// - eight sources per group merged into one core line, twelve groups
// - per-group enable and flag registers gate requests and pick the vector
// - servicing a source through its vector clears its group flag
// - expansion table writes accepted only while protected writes are permitted
// - wake input synchronised to the system clock before the controller
// - two external pins and nonmaskable pin synchronised, optionally qualified
// - 45 of the 96 group slots have sources, the rest are unconnected
// - flagged enabled request forwarded only while group ack is clear
// - vector is highest-priority flagged and enabled slot, else first slot
package intc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [15:0] EXT_IF_CONFIG_TWO_OFFSET = 16'h0B34;
    localparam logic [15:0] EXPANSION_CONTROL_OFFSET = 16'h0CE0;
    localparam logic [15:0] GROUP_ACK_OFFSET = 16'h0C04;
    localparam logic [15:0] CORE_STATUS_ONE_OFFSET = 16'h0C08;
    localparam logic [15:0] QUAL_CYCLES_OFFSET = 16'h0C0C;
    localparam logic [15:0] ENABLE_BASE = 16'h0C40;
    localparam logic [15:0] FLAG_BASE = 16'h0C80;
    localparam logic [15:0] TABLE_BASE = 16'h1000;
    localparam logic [15:0] TABLE_END = 16'h1200;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int VECTOR_MAP_BIT = 3;
    localparam int LOW_RAM_MAP_BIT = 11;
    localparam int BOOT_SOURCE_BIT = 8;
    localparam int EXPANSION_ENABLE_BIT = 0;
    localparam logic VECTOR_MAP_RESET = 1'b1;
    localparam logic LOW_RAM_MAP_RESET = 1'b1;
    localparam logic EXPANSION_ENABLE_RESET = 1'b0;
    localparam logic [7:0] QUAL_CYCLES_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // grouping and vector table layout
    localparam int GROUPS = 12;
    localparam int SLOTS = 8;
    localparam int SLOTS_USED = 45;
    localparam int TABLE_WORDS = 128;
    localparam logic [6:0] GROUP_VECTOR_BASE = 7'h20;
    localparam logic [6:0] RESET_VECTOR_ID = 7'h00;

    // fetch regions, in 16-bit word addresses
    localparam logic [21:0] LOW_RAM_REGION = 22'h000000;
    localparam logic [21:0] BOOT_REGION = 22'h3FFFC0;
    localparam logic [21:0] EXPANSION_REGION = 22'h000D00;

    typedef enum logic [2:0] {
        SRC_LOW_RAM_UPPER = 3'b000,
        SRC_LOW_RAM_LOWER = 3'b001,
        SRC_BOOT_ROM = 3'b010,
        SRC_EXT_ZONE7 = 3'b011,
        SRC_EXPANSION = 3'b100
    } vec_source_t;

endpackage : intc_pkg

// [core/pin_sync_qual.sv]
`timescale 1ns/10ps
// two-stage synchroniser per pin, then an optional stability qualifier
module pin_sync_qual
    import intc_pkg::*;
#(
    parameter int PINS = 4,
    parameter logic [PINS-1:0] QUAL_MASK = '1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [7:0] qualCycles,
    output logic [PINS-1:0] pinOut
);

    typedef struct packed {
        logic [PINS-1:0] meta;
        logic [PINS-1:0] sync;
        logic [PINS-1:0] out;
        logic [PINS-1:0][7:0] count;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // the first stage feeds only the second; the counter watches the second
    always_comb begin
        state_next = state_reg;
        state_next.meta = pinIn;
        state_next.sync = state_reg.meta;
        for (int i = 0; i < PINS; i++) begin
            if (!QUAL_MASK[i] || state_reg.sync[i] == state_reg.out[i]) begin
                state_next.out[i] = state_reg.sync[i];
                state_next.count[i] = 8'h00;
            end else if (state_reg.count[i] >= qualCycles) begin
                // glitches shorter than the programmed period never pass
                state_next.out[i] = state_reg.sync[i];
                state_next.count[i] = 8'h00;
            end else begin
                state_next.count[i] = state_reg.count[i] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pinOut = state_reg.out;

endmodule : pin_sync_qual

// [core/group_priority.sv]
`timescale 1ns/10ps
// picks the highest-priority (lowest index) slot that is flagged and enabled
module group_priority
    import intc_pkg::*;
(
    input wire logic [SLOTS-1:0] flag,
    input wire logic [SLOTS-1:0] enable,
    output logic hit,
    output logic [2:0] slot
);

    logic [SLOTS-1:0] live;

    assign live = flag & enable;

    ////////////////////////////////////////////////////////////////////////////////
    // no live slot falls back to the first slot
    always_comb begin
        hit = 1'b0;
        slot = 3'h0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (live[i]) begin
                hit = 1'b1;
                slot = 3'(i);
            end
        end
    end

endmodule : group_priority

// [core/interrupt_vector_map_and_group_mux.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module interrupt_vector_map_and_group_mux
    import intc_pkg::*;
#(
    parameter int SRC_COUNT = GROUPS * SLOTS,
    parameter logic [SRC_COUNT-1:0] SLOT_CONNECTED = SRC_COUNT'((97'h1 << SLOTS_USED) - 97'h1),
    parameter int EXT_ONE_SLOT = 3,
    parameter int EXT_TWO_SLOT = 4,
    parameter int WAKE_SLOT = 7
) (
    input wire logic clk_sys,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic bootSourcePin,
    input wire logic protectedWritePermit,
    input wire logic vectorMapSet,
    input wire logic vectorMapClear,
    input wire logic lowRamMapSet,
    input wire logic lowRamMapClear,
    input wire logic vecReq,
    input wire logic [6:0] vecId,
    output logic vecValid,
    output logic [21:0] vecFetchAddr,
    output logic [31:0] vecData,
    output logic [2:0] vecSource,
    output logic [GROUPS-1:0] coreInt,
    output logic nmiReq,
    output logic [1:0] lowRamVectorUse,
    // sources
    input wire logic [SRC_COUNT-1:0] periphIrq,
    input wire logic extInterruptOne,
    input wire logic extInterruptTwo,
    input wire logic extNonmaskable,
    input wire logic wakeInterrupt
);

    typedef struct packed {
        logic vectorMapSelect;
        logic lowRamMapSelect;
        logic bootSourceBit;
        logic expansionEnable;
        logic [GROUPS-1:0][SLOTS-1:0] groupEnable;
        logic [GROUPS-1:0][SLOTS-1:0] groupFlag;
        logic [GROUPS-1:0] groupAck;
        logic [7:0] qualCycles;
        logic [SRC_COUNT-1:0] srcPrev;
        logic [TABLE_WORDS-1:0][31:0] vectorTable;
        logic [GROUPS-1:0] coreInt;
        logic nmiReq;
        logic vecValid;
        logic [21:0] vecFetchAddr;
        logic [31:0] vecData;
        logic [2:0] vecSource;
        logic [1:0] lowRamVectorUse;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mux_state_t;

    mux_state_t state_reg;
    mux_state_t state_next;

    logic [3:0] pinsSynced;
    logic [SRC_COUNT-1:0] srcLevel;
    logic isGroupVec;
    logic [3:0] reqGroup;
    logic [SLOTS-1:0] reqFlag;
    logic [SLOTS-1:0] reqEnable;
    logic reqHit;
    logic [2:0] reqSlot;

    ////////////////////////////////////////////////////////////////////////////////
    // pin conditioning: wake is synchronised only, the others are qualified too
    pin_sync_qual #(
        .PINS(4),
        .QUAL_MASK(4'h7)
    ) pinCond (
        .clk_sys(clk_sys),
        .reset(reset),
        .pinIn({wakeInterrupt, extNonmaskable, extInterruptTwo, extInterruptOne}),
        .qualCycles(state_reg.qualCycles),
        .pinOut(pinsSynced)
    );

    // unconnected slots can never raise a flag
    always_comb begin
        srcLevel = periphIrq;
        srcLevel[EXT_ONE_SLOT] = pinsSynced[0];
        srcLevel[EXT_TWO_SLOT] = pinsSynced[1];
        srcLevel[WAKE_SLOT] = pinsSynced[3];
        srcLevel = srcLevel & SLOT_CONNECTED;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // group vector decode for the requested core line
    assign isGroupVec = (vecId >= 7'd1) && (vecId <= 7'(GROUPS));
    assign reqGroup = isGroupVec ? 4'(vecId - 7'd1) : 4'h0;
    assign reqFlag = state_reg.groupFlag[reqGroup];
    assign reqEnable = state_reg.groupEnable[reqGroup];

    group_priority pick (
        .flag(reqFlag),
        .enable(reqEnable),
        .hit(reqHit),
        .slot(reqSlot)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [6:0] tableIdx;
        logic [15:0] regAddr;
        logic access;
        logic setup;
        tableIdx = 7'h00;
        regAddr = {paddr[15:2], 2'b00};
        access = psel && penable && state_reg.pready;
        setup = psel && !penable;
        state_next = state_reg;
        state_next.vecValid = 1'b0;
        state_next.coreInt = '0;
        state_next.pready = 1'b0;
        state_next.srcPrev = srcLevel;
        state_next.nmiReq = pinsSynced[2];

        // core status bit instructions; set wins over clear
        if (vectorMapClear) begin
            state_next.vectorMapSelect = 1'b0;
        end
        if (vectorMapSet) begin
            state_next.vectorMapSelect = 1'b1;
        end
        if (lowRamMapClear) begin
            state_next.lowRamMapSelect = 1'b0;
        end
        if (lowRamMapSet) begin
            state_next.lowRamMapSelect = 1'b1;
        end

        // register writes take effect at the access edge
        if (access && pwrite) begin
            if (regAddr == CORE_STATUS_ONE_OFFSET) begin
                state_next.vectorMapSelect = pwdata[VECTOR_MAP_BIT];
                state_next.lowRamMapSelect = pwdata[LOW_RAM_MAP_BIT];
            end else if (regAddr == EXT_IF_CONFIG_TWO_OFFSET) begin
                state_next.bootSourceBit = pwdata[BOOT_SOURCE_BIT];
            end else if (regAddr == EXPANSION_CONTROL_OFFSET) begin
                state_next.expansionEnable = pwdata[EXPANSION_ENABLE_BIT];
            end else if (regAddr == QUAL_CYCLES_OFFSET) begin
                state_next.qualCycles = pwdata[7:0];
            end else if (regAddr == GROUP_ACK_OFFSET) begin
                // write one to release a group
                state_next.groupAck = state_reg.groupAck & ~pwdata[GROUPS-1:0];
            end else if (regAddr >= TABLE_BASE && regAddr < TABLE_END) begin
                if (protectedWritePermit) begin
                    state_next.vectorTable[paddr[8:2]] = pwdata;
                end
            end
            for (int g = 0; g < GROUPS; g++) begin
                if (regAddr == ENABLE_BASE + 16'(4 * g)) begin
                    state_next.groupEnable[g] = pwdata[SLOTS-1:0];
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // vector fetch: answered one cycle after the request
        if (vecReq) begin
            state_next.vecValid = 1'b1;
            if (vecId == RESET_VECTOR_ID) begin
                // reset vector ignores every mode bit except the pin
                state_next.vecSource = bootSourcePin ? SRC_EXT_ZONE7 : SRC_BOOT_ROM;
                state_next.vecFetchAddr = BOOT_REGION;
                state_next.vecData = 32'h0000_0000;
            end else begin
                tableIdx = isGroupVec ? GROUP_VECTOR_BASE + 7'({reqGroup, reqSlot}) : vecId;
                if (!state_reg.vectorMapSelect) begin
                    state_next.vecSource = state_reg.lowRamMapSelect ? SRC_LOW_RAM_LOWER
                                                                     : SRC_LOW_RAM_UPPER;
                    // low and boot maps hold only 32 vectors, so five id bits count
                    state_next.vecFetchAddr = LOW_RAM_REGION + 22'({vecId[4:0], 1'b0});
                    state_next.vecData = 32'h0000_0000;
                end else if (state_reg.expansionEnable) begin
                    // every vector but reset comes from the table
                    state_next.vecSource = SRC_EXPANSION;
                    state_next.vecFetchAddr = EXPANSION_REGION + 22'({tableIdx, 1'b0});
                    state_next.vecData = state_reg.vectorTable[tableIdx];
                end else begin
                    state_next.vecSource = state_reg.bootSourceBit ? SRC_EXT_ZONE7 : SRC_BOOT_ROM;
                    state_next.vecFetchAddr = BOOT_REGION + 22'({vecId[4:0], 1'b0});
                    state_next.vecData = 32'h0000_0000;
                end
                // servicing clears the winning flag
                if (isGroupVec && reqHit) begin
                    state_next.groupFlag[reqGroup][reqSlot] = 1'b0;
                end
            end
        end

        // new events set flags after any clear, so a coincident event survives
        for (int g = 0; g < GROUPS; g++) begin
            for (int s = 0; s < SLOTS; s++) begin
                if (srcLevel[g * SLOTS + s] && !state_reg.srcPrev[g * SLOTS + s]) begin
                    state_next.groupFlag[g][s] = 1'b1;
                end
            end
            // forward and hold back further requests until ack is cleared
            if (|(state_reg.groupFlag[g] & state_reg.groupEnable[g]) && !state_reg.groupAck[g]) begin
                state_next.coreInt[g] = 1'b1;
                state_next.groupAck[g] = 1'b1;
            end
        end

        // low RAM blocks carry vectors only in the test maps
        state_next.lowRamVectorUse = 2'b00;
        if (!state_next.vectorMapSelect) begin
            state_next.lowRamVectorUse = state_next.lowRamMapSelect ? 2'b01 : 2'b10;
        end

        ////////////////////////////////////////////////////////////////////////////
        // read data captured in setup so the access phase answers at once
        if (setup) begin
            state_next.pready = 1'b1;
            state_next.pslverr = 1'b0;
            state_next.prdata = 32'h0000_0000;
            if (regAddr == CORE_STATUS_ONE_OFFSET) begin
                state_next.prdata[VECTOR_MAP_BIT] = state_reg.vectorMapSelect;
                state_next.prdata[LOW_RAM_MAP_BIT] = state_reg.lowRamMapSelect;
            end else if (regAddr == EXT_IF_CONFIG_TWO_OFFSET) begin
                state_next.prdata[BOOT_SOURCE_BIT] = state_reg.bootSourceBit;
            end else if (regAddr == EXPANSION_CONTROL_OFFSET) begin
                state_next.prdata[EXPANSION_ENABLE_BIT] = state_reg.expansionEnable;
            end else if (regAddr == QUAL_CYCLES_OFFSET) begin
                state_next.prdata[7:0] = state_reg.qualCycles;
            end else if (regAddr == GROUP_ACK_OFFSET) begin
                state_next.prdata[GROUPS-1:0] = state_reg.groupAck;
            end else if (regAddr >= TABLE_BASE && regAddr < TABLE_END) begin
                state_next.prdata = state_reg.vectorTable[paddr[8:2]];
                // refused table write is reported, not stored
                state_next.pslverr = pwrite && !protectedWritePermit;
            end else begin
                state_next.pslverr = 1'b1;
                for (int g = 0; g < GROUPS; g++) begin
                    if (regAddr == ENABLE_BASE + 16'(4 * g)) begin
                        state_next.prdata[SLOTS-1:0] = state_reg.groupEnable[g];
                        state_next.pslverr = 1'b0;
                    end
                    // flags are read-only here; only servicing clears them
                    if (regAddr == FLAG_BASE + 16'(4 * g)) begin
                        state_next.prdata[SLOTS-1:0] = state_reg.groupFlag[g];
                        state_next.pslverr = pwrite;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; the boot pin is sampled by the synchronous reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.vectorMapSelect <= VECTOR_MAP_RESET;
            state_reg.lowRamMapSelect <= LOW_RAM_MAP_RESET;
            state_reg.bootSourceBit <= bootSourcePin;
            state_reg.expansionEnable <= EXPANSION_ENABLE_RESET;
            state_reg.qualCycles <= QUAL_CYCLES_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign vecValid = state_reg.vecValid;
    assign vecFetchAddr = state_reg.vecFetchAddr;
    assign vecData = state_reg.vecData;
    assign vecSource = state_reg.vecSource;
    assign coreInt = state_reg.coreInt;
    assign nmiReq = state_reg.nmiReq;
    assign lowRamVectorUse = state_reg.lowRamVectorUse;

endmodule : interrupt_vector_map_and_group_mux

// [tb/intc_assertions.sv]
`timescale 1ns/10ps
module intc_assertions
    import intc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic protectedWritePermit,
    input wire logic vecReq,
    input wire logic [6:0] vecId,
    input wire logic vecValid,
    input wire logic [21:0] vecFetchAddr,
    input wire logic [2:0] vecSource,
    input wire logic [GROUPS-1:0] coreInt,
    input wire logic [1:0] lowRamVectorUse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // bus and vector handshakes
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no zero-wait answer");
    property p_vec; vecReq |=> vecValid; endproperty
    a_vec: assert property (p_vec) else $error("vector answer missing");
    property p_rst_vec; vecReq && vecId == 7'h00 |=> vecSource inside {3'h2, 3'h3}; endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset vector source");
    // fetch address lies in the selected region
    property p_low_addr;
        vecValid && vecSource <= 3'h1 |-> vecFetchAddr <= 22'h00003F;
    endproperty
    a_low_addr: assert property (p_low_addr) else $error("low map address");
    property p_boot_addr;
        vecValid && vecSource inside {3'h2, 3'h3} |-> vecFetchAddr >= BOOT_REGION;
    endproperty
    a_boot_addr: assert property (p_boot_addr) else $error("boot map address");
    property p_exp_addr; vecValid && vecSource == 3'h4 |-> vecFetchAddr[21:8] == 14'h000D;
    endproperty
    a_exp_addr: assert property (p_exp_addr) else $error("expansion address");
    // ack must hold back a second pulse of the same group
    property p_int_once; coreInt != 12'h000 |=> (coreInt & $past(coreInt)) == 12'h000;
    endproperty
    a_int_once: assert property (p_int_once) else $error("group line repeated");
    property p_low_use;
        vecValid && vecSource <= 3'h1 |-> lowRamVectorUse == {vecSource == 3'h0, vecSource == 3'h1};
    endproperty
    a_low_use: assert property (p_low_use) else $error("low RAM use flags");
    property p_tbl_lock;
        psel && penable && pwrite && !protectedWritePermit && !$past(protectedWritePermit)
            && paddr >= TABLE_BASE && paddr < TABLE_END |-> pslverr;
    endproperty
    a_tbl_lock: assert property (p_tbl_lock) else $error("table write not refused");
    c_exp: cover property (vecValid && vecSource == 3'h4);
    c_int: cover property (coreInt[0]);
    c_err: cover property (pready && pslverr);
endmodule : intc_assertions

bind interrupt_vector_map_and_group_mux intc_assertions intc_assertions_inst (.clk_sys,
    .reset, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .protectedWritePermit,
    .vecReq, .vecId, .vecValid, .vecFetchAddr, .vecSource, .coreInt, .lowRamVectorUse);

// [tb/core_model.sv]
`timescale 1ns/10ps
module core_model
    import intc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [GROUPS-1:0] coreInt,
    input wire logic [3:0] serviceLag,
    output logic vecReq,
    output logic [6:0] vecId,
    output logic [3:0] mapPulse
);
    logic [6:0] grp;
    initial begin
        vecReq = 1'b0;
        vecId = 7'h00;
        mapPulse = 4'h0;
    end
    // services a group line after a lag; lowest group first, as the core orders them
    always @(posedge clk_sys) begin
        if (!reset && coreInt != 12'h000) begin
            grp = 7'h00;
            for (int i = GROUPS - 1; i >= 0; i--) if (coreInt[i]) grp = 7'(i + 1);
            repeat (serviceLag) @(posedge clk_sys);
            vecReq <= 1'b1;
            vecId <= grp;
            @(posedge clk_sys);
            vecReq <= 1'b0;
        end
    end
    // plain fetch; returns once the answer stands
    task request(input logic [6:0] id);
        @(posedge clk_sys);
        vecReq <= 1'b1;
        vecId <= id;
        @(posedge clk_sys);
        vecReq <= 1'b0;
        #1;
    endtask : request
    // one-cycle set/clear instruction pulses
    task pulse(input logic [3:0] which);
        @(posedge clk_sys);
        mapPulse <= which;
        @(posedge clk_sys);
        mapPulse <= 4'h0;
    endtask : pulse
endmodule : core_model

// [tb/interrupt_vector_map_and_group_mux_test.sv]
`timescale 1ns/10ps
module interrupt_vector_map_and_group_mux_test;
    import intc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, vecReq, vecValid, nmiReq, bootSourcePin = 1'b1;
    logic permit = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [6:0] vecId;
    logic [3:0] mapPulse, lag = 4'h0;
    logic [21:0] vecFetchAddr;
    logic [31:0] vecData;
    logic [2:0] vecSource;
    logic [11:0] coreInt;
    logic [1:0] lowRamVectorUse;
    logic [95:0] irq = 96'h0;
    int error_cnt = 0, tests_run = 0;
    always #20 clk_sys = ~clk_sys;
    interrupt_vector_map_and_group_mux interrupt_vector_map_and_group_mux_inst (.clk_sys,
        .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .bootSourcePin, .protectedWritePermit(permit), .vectorMapSet(mapPulse[0]),
        .vectorMapClear(mapPulse[1]), .lowRamMapSet(mapPulse[2]), .lowRamMapClear(mapPulse[3]),
        .vecReq, .vecId, .vecValid, .vecFetchAddr, .vecData, .vecSource, .coreInt, .nmiReq,
        .lowRamVectorUse, .periphIrq(irq), .extInterruptOne(pins[0]), .extInterruptTwo(pins[1]),
        .extNonmaskable(pins[2]), .wakeInterrupt(pins[3]));
    core_model core_model_inst (.clk_sys, .reset, .coreInt, .serviceLag(lag), .vecReq,
        .vecId, .mapPulse);
    ////////////////////////////////////////
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // one apb transfer; held until pready is sampled high
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task req(input logic [6:0] id, input logic [2:0] src, input logic [21:0] adr);
        core_model_inst.request(id);
        chk(32'(vecSource), 32'(src), "source");
        chk(32'(vecFetchAddr), 32'(adr), "address");
        chk(32'(vecValid), 32'h1, "valid");
    endtask : req
    // polls a settled output for a bounded span
    task wait_int(output logic seen);
        seen = 1'b0;
        repeat (12) begin @(posedge clk_sys); #1; if (coreInt[0] === 1'b1) seen = 1'b1; end
    endtask : wait_int
    task wait_vec;
        for (int n = 0; n < 12 && vecValid !== 1'b1; n++) begin @(posedge clk_sys); #1; end
    endtask : wait_vec
    initial begin repeat (4000) @(posedge clk_sys); error_cnt++; end_of_test(); end
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        apb(0, EXT_IF_CONFIG_TWO_OFFSET, 0); chk(rd, 32'h100, "boot bit");
        apb(0, EXPANSION_CONTROL_OFFSET, 0); chk(rd, 32'h0, "exp reset");
        apb(0, CORE_STATUS_ONE_OFFSET, 0); chk(rd, 32'h808, "status");
        req(7'd20, SRC_EXT_ZONE7, 22'h3FFFE8);
        apb(1, EXT_IF_CONFIG_TWO_OFFSET, 0); apb(0, EXT_IF_CONFIG_TWO_OFFSET, 0);
        chk(rd, 32'h0, "boot bit write");
        req(7'd20, SRC_BOOT_ROM, 22'h3FFFE8);
        $display("test map done");
        apb(1, 16'h1080, 32'hA5A50001); chk(32'(err), 32'h1, "locked");
        apb(0, 16'h1080, 0); chk(rd, 32'h0, "locked data");
        permit <= 1'b1;
        apb(1, 16'h1080, 32'hA5A50001); chk(32'(err), 32'h0, "permit");
        apb(1, 16'h1088, 32'hA5A50003);
        permit <= 1'b0;
        apb(1, EXPANSION_CONTROL_OFFSET, 1); apb(0, EXPANSION_CONTROL_OFFSET, 0);
        chk(rd, 32'h1, "exp on");
        req(7'd0, SRC_EXT_ZONE7, 22'h3FFFC0);
        req(7'd20, SRC_EXPANSION, 22'h000D28);
        $display("test table done");
        apb(1, ENABLE_BASE, 32'h5);
        irq[0] <= 1'b1;
        wait_int(err); chk(32'(err), 32'h1, "line");
        wait_vec(); chk(vecData, 32'hA5A50001, "slot0");
        chk(32'(vecFetchAddr), 32'h000D40, "slot0 addr");
        apb(0, FLAG_BASE, 0); chk(rd, 32'h0, "flag cleared");
        lag <= 4'h3;
        irq[2] <= 1'b1;
        wait_int(err); chk(32'(err), 32'h0, "held by ack");
        apb(0, FLAG_BASE, 0); chk(rd, 32'h4, "flag");
        apb(1, FLAG_BASE, 0); chk(32'(err), 32'h1, "flag write");
        apb(1, GROUP_ACK_OFFSET, 1);
        wait_int(err); chk(32'(err), 32'h1, "released");
        wait_vec(); chk(vecData, 32'hA5A50003, "slot2");
        core_model_inst.request(7'd1); chk(vecData, 32'hA5A50001, "none live");
        $display("test groups done");
        core_model_inst.pulse(4'h2);
        apb(0, CORE_STATUS_ONE_OFFSET, 0); chk(rd, 32'h800, "map clear");
        req(7'd20, SRC_LOW_RAM_LOWER, 22'h000028);
        chk(32'(lowRamVectorUse), 32'h1, "lower");
        core_model_inst.pulse(4'h8);
        req(7'd20, SRC_LOW_RAM_UPPER, 22'h000028);
        chk(32'(lowRamVectorUse), 32'h2, "upper");
        core_model_inst.pulse(4'h5);
        req(7'd20, SRC_EXPANSION, 22'h000D28);
        chk(32'(lowRamVectorUse), 32'h0, "plain RAM");
        apb(0, 16'h0200, 0); chk(32'(err), 32'h1, "unmapped");
        pins <= 4'hF;
        repeat (10) @(posedge clk_sys);
        chk(32'(nmiReq), 32'h1, "nmi");
        apb(0, FLAG_BASE, 0); chk(rd, 32'h98, "pin flags");
        $display("test modes done");
        end_of_test();
    end
endmodule : interrupt_vector_map_and_group_mux_test
